// ### common/eepc_pkg.sv
// Purpose: shared constants and types of the nvm program/erase control
// Assumes: 32-bit classic wishbone, 8-bit registers in the low lanes
// Notes:   byte address of a register is four times its index
package eepc_pkg;

    // bus geometry
    localparam int unsigned WB_AW = 10;
    localparam int unsigned WB_DW = 32;

    // register indices, byte address = index * 4
    localparam logic [7:0] IDX_CFG  = 8'hF0;
    localparam logic [7:0] IDX_PROT = 8'hF1;
    localparam logic [7:0] IDX_TST  = 8'hF2;
    localparam logic [7:0] IDX_PGM  = 8'hF3;

    // module config fields
    localparam int unsigned CFG_WSTOP = 7;
    localparam int unsigned CFG_LOCK  = 1;
    localparam int unsigned CFG_RC    = 0;

    // test control fields
    localparam int unsigned TST_ODD  = 7;
    localparam int unsigned TST_EVEN = 6;
    localparam int unsigned TST_VOLTAGE_MARGIN_TEST = 3;
    localparam int unsigned TST_CPD  = 2;
    localparam int unsigned TST_CPRD = 1;
    localparam int unsigned TST_CPM  = 0;

    // program control fields
    localparam int unsigned PGM_BULK_ERASE_PROTECT = 7;
    localparam int unsigned PGM_BYTE  = 4;
    localparam int unsigned PGM_ROW   = 3;
    localparam int unsigned PGM_ERASE = 2;
    localparam int unsigned PGM_LAT   = 1;
    localparam int unsigned PGM_VEN   = 0;

    // reset values
    localparam logic [7:0] RST_CFG  = 8'h00;
    localparam logic [7:0] RST_PROT = 8'h00;
    localparam logic [7:0] RST_TST  = 8'h00;
    localparam logic [7:0] RST_PGM  = 8'h80;

    // array geometry, offsets from the array base
    localparam int unsigned ARR_AW = 10;
    localparam logic [9:0] BLK3_START = 10'h100;
    localparam logic [9:0] BLK2_START = 10'h200;
    localparam logic [9:0] BLK1_START = 10'h280;
    localparam logic [9:0] BLK0_START = 10'h2C0;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // operation kinds handed to the array
    typedef enum logic [2:0] {
        OP_PROGRAM, OP_ERASE_LOC, OP_ERASE_ROW,
        OP_ERASE_BULK, OP_BULK_ODD, OP_BULK_EVEN
    } eepc_op_kind_t;

    // programming latches
    typedef struct packed {
        logic [9:0]  addr;
        logic [15:0] data;
        logic        word;
    } eepc_latch_t;

    // command toward the array
    typedef struct packed {
        logic          active;
        eepc_op_kind_t kind;
        eepc_latch_t   lat;
    } eepc_op_cmd_t;

    // analog pump controls
    typedef struct packed {
        logic hv_apply;
        logic pump_en;
        logic rc_osc_en;
        logic clk_sel_rc;
        logic ramp_en;
        logic monitor;
        logic margin;
    } eepc_pump_t;

endpackage

// ### logic/eepc_ctrl.sv
// Purpose: register file and interlocks of the nvm program/erase control
// Assumes: array port and mode inputs synchronous to i_clk
// Notes:   array storage and read datapath live outside this block
//
// Functional notes
// - wait-clock-stop set gates the module clock off in wait mode
// - protect lock writes once in normal modes, freely in special
// - protect lock set freezes block protect and bulk protect bits
// - pump clock select picks system clock or running rc oscillator
// - five protect bits guard 256,256,128,64,64 byte blocks
// - block protect readable always, writable when unlocked and idle
// - test bits writable in special modes, held zero in normal
// - odd/even test bits make bulk act on physical odd/even rows
// - test bits give margin, pump off, ramp off and pump monitor
// - program control resets to 0x80, bits 6 and 5 read zero
// - single-location and row bits choose bulk, row or location
// - without erase bit the operation is programming; the code makes it odd/even bulk when an odd/even test bit is set
// - location erase acts on latched address at latched width
// - voltage enable freezes mode bits and the latches
// - latch enable makes the array unreadable
// - mode bits may be written together or in any order
// - voltage enable sets only when latch enable is already set
// - voltage enable applies program/erase voltage, clear removes it
// - array writes ignored while voltage enable is set
// - erasure leaves all-ones bytes
// - misaligned word target latches only its lower byte
// - stop mode removes voltage and rc clock, restores on exit
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/100ps
module eepc_ctrl (
    // clock and reset
    input  wire logic                      i_clk,
    input  wire logic                      i_rstn,
    // wishbone slave
    input  wire logic                      i_wb_cyc,
    input  wire logic                      i_wb_stb,
    input  wire logic                      i_wb_we,
    input  wire logic [eepc_pkg::WB_AW-1:0] i_wb_adr,
    input  wire logic [eepc_pkg::WB_DW-1:0] i_wb_dat,
    input  wire logic [3:0]                i_wb_sel,
    output logic [eepc_pkg::WB_DW-1:0]     o_wb_dat,
    output logic                           o_wb_ack,
    // array write port from the cpu
    input  wire logic                      i_arr_wr,
    input  wire logic [9:0]                i_arr_addr,
    input  wire logic                      i_arr_word,
    input  wire logic [15:0]               i_arr_wdata,
    // device modes
    input  wire logic                      i_special_mode_n,
    input  wire logic                      i_wait,
    input  wire logic                      i_stop,
    // to array, pump and clock tree
    output logic                           o_arr_rd_block,
    output eepc_pkg::eepc_op_cmd_t         o_op,
    output eepc_pkg::eepc_pump_t           o_pump,
    output logic                           o_clk_en
);
    import eepc_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // register state
    logic       wstop_r;
    logic       lock_r;
    logic       lock_used_r;
    logic       rc_r;
    logic [4:0] bprot_r;
    logic [7:0] tst_r;
    logic       bulk_erase_protect_r;
    logic       byte_r;
    logic       row_r;
    logic       erase_r;
    logic       lat_r;
    logic       ven_r;
    logic       ack_r;
    logic       loaded_r;
    eepc_latch_t latch_r;
    eepc_latch_t latch_nxt;

    ////////////////////////////////////////////////////////////////////
    // bus decode
    logic [7:0] idx;
    logic       req;
    logic       wr;
    logic [7:0] wd;
    logic       special;

    assign idx     = i_wb_adr[9:2];
    assign req     = i_wb_cyc && i_wb_stb;
    // write lands on the edge at which the master sees ack
    assign wr      = req && i_wb_we && ack_r && i_wb_sel[0];
    assign wd      = i_wb_dat[7:0];
    assign special = !i_special_mode_n;

    // one strobe per register, shared by all write processes
    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] r);
        hit = (a == r);
    endfunction

    logic wr_cfg;
    logic wr_prot;
    logic wr_tst;
    logic wr_pgm;
    assign wr_cfg  = wr && hit(idx, IDX_CFG);
    assign wr_prot = wr && hit(idx, IDX_PROT);
    assign wr_tst  = wr && hit(idx, IDX_TST);
    assign wr_pgm  = wr && hit(idx, IDX_PGM);

    ////////////////////////////////////////////////////////////////////
    // ack: one wait state, dropped the cycle after it is given
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req && !ack_r;
        end
    end
    assign o_wb_ack = ack_r;

    ////////////////////////////////////////////////////////////////////
    // module config: wait stop and pump clock, write anytime
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            wstop_r <= RST_CFG[CFG_WSTOP];
            rc_r    <= RST_CFG[CFG_RC];
        end else if (wr_cfg) begin
            wstop_r <= wd[CFG_WSTOP];
            rc_r    <= wd[CFG_RC];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // protect lock: one write after reset unless in special mode
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            lock_r      <= RST_CFG[CFG_LOCK];
            lock_used_r <= 1'b0;
        end else if (wr_cfg && (special || !lock_used_r)) begin
            lock_r      <= wd[CFG_LOCK];
            lock_used_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // block protect, frozen by lock or an operation in progress
    logic prot_open;
    assign prot_open = !lock_r && !ven_r;

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            bprot_r <= RST_PROT[4:0];
        end else if (wr_prot && prot_open) begin
            bprot_r <= wd[4:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // test controls only live in special modes
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            tst_r <= RST_TST;
        end else if (!special) begin
            tst_r <= RST_TST;
        end else if (wr_tst) begin
            tst_r <= wd;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // program control, mode bits locked while voltage is on
    // the write that drops voltage may also drop the latch bit, so one
    // write ends an operation and frees the array
    logic ven_clr;
    assign ven_clr = wr_pgm && ven_r && !wd[PGM_VEN];

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            bulk_erase_protect_r <= RST_PGM[PGM_BULK_ERASE_PROTECT];
            byte_r  <= RST_PGM[PGM_BYTE];
            row_r   <= RST_PGM[PGM_ROW];
            erase_r <= RST_PGM[PGM_ERASE];
            lat_r   <= RST_PGM[PGM_LAT];
        end else if (wr_pgm && (!ven_r || ven_clr)) begin
            if (prot_open) begin
                bulk_erase_protect_r <= wd[PGM_BULK_ERASE_PROTECT];
            end
            // each bit stands alone, so any write order works
            byte_r  <= wd[PGM_BYTE];
            row_r   <= wd[PGM_ROW];
            erase_r <= wd[PGM_ERASE];
            lat_r   <= wd[PGM_LAT];
        end
    end

    // voltage enable judges the old latch bit, not the written one
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            ven_r <= RST_PGM[PGM_VEN];
        end else if (wr_pgm) begin
            ven_r <= wd[PGM_VEN] && lat_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // programming latches
    always_comb begin
        latch_nxt.addr = i_arr_addr;
        latch_nxt.word = i_arr_word;
        latch_nxt.data = i_arr_wdata;
        if (i_arr_word && i_arr_addr[0]) begin
            latch_nxt.word = 1'b0;
            latch_nxt.data = {8'h00, i_arr_wdata[7:0]};
        end
    end

    // loaded clears when voltage drops so a fresh target can be taken
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            loaded_r <= 1'b0;
        end else if (!lat_r || ven_clr) begin
            loaded_r <= 1'b0;
        end else if (i_arr_wr && !ven_r) begin
            loaded_r <= 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            latch_r <= '0;
        end else if (i_arr_wr && lat_r && !ven_r
                     && !loaded_r) begin
            latch_r <= latch_nxt; // frozen otherwise
        end
    end

    ////////////////////////////////////////////////////////////////////
    // operation decode
    eepc_op_kind_t kind;
    always_comb begin
        if (!erase_r) begin
            kind = OP_PROGRAM;
        end else if (byte_r) begin
            kind = OP_ERASE_LOC;
        end else if (row_r) begin
            kind = OP_ERASE_ROW;
        end else begin
            kind = OP_ERASE_BULK;
        end
        // test rows override every kind except location erase
        if (kind != OP_ERASE_LOC) begin
            if (tst_r[TST_ODD]) begin
                kind = OP_BULK_ODD;
            end else if (tst_r[TST_EVEN]) begin
                kind = OP_BULK_EVEN;
            end
        end
    end

    logic prot_hit;
    eepc_prot_decode u_prot (
        .i_addr  (latch_r.addr),
        .i_bprot (bprot_r),
        .o_hit   (prot_hit)
    );

    // guard: bulk must see no protected block at all
    logic allowed;
    always_comb begin
        case (kind)
            OP_PROGRAM, OP_ERASE_LOC: begin
                allowed = !prot_hit;
            end
            OP_ERASE_ROW: begin
                allowed = !prot_hit && !bulk_erase_protect_r;
            end
            OP_ERASE_BULK, OP_BULK_ODD, OP_BULK_EVEN: begin
                allowed = !bulk_erase_protect_r && (bprot_r == 5'h00);
            end
            default: begin
                allowed = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // pump gating, including stop handling
    eepc_pump_ctrl u_pump (
        .i_clk    (i_clk),
        .i_rstn   (i_rstn),
        .i_ven    (ven_r),
        .i_stop   (i_stop),
        .i_rc_sel (rc_r),
        .i_tst    (tst_r),
        .o_pump   (o_pump)
    );

    ////////////////////////////////////////////////////////////////////
    // command to the array, registered
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_op <= '0;
        end else begin
            o_op.active <= ven_r && !i_stop && loaded_r
                           && allowed;
            o_op.kind   <= kind;
            o_op.lat    <= latch_r;
            if (kind != OP_PROGRAM) begin
                // erase writes ones over the whole target
                o_op.lat.data <= {ERASED_BYTE, ERASED_BYTE};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read blocking and clock gating
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_arr_rd_block <= 1'b0;
            o_clk_en       <= 1'b1;
        end else begin
            o_arr_rd_block <= lat_r;
            o_clk_en       <= !(wstop_r && i_wait);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read mux, captured in the request cycle, shown with ack
    logic [7:0] rd;
    always_comb begin
        case (idx)
            IDX_CFG: begin
                rd = '0;
                rd[CFG_WSTOP] = wstop_r;
                rd[CFG_LOCK]  = lock_r;
                rd[CFG_RC]    = rc_r;
            end
            IDX_PROT: begin
                rd = {3'h0, bprot_r};
            end
            IDX_TST: begin
                rd = tst_r;
            end
            IDX_PGM: begin
                rd = '0; // bits 6 and 5 stay zero
                rd[PGM_BULK_ERASE_PROTECT] = bulk_erase_protect_r;
                rd[PGM_BYTE]  = byte_r;
                rd[PGM_ROW]   = row_r;
                rd[PGM_ERASE] = erase_r;
                rd[PGM_LAT]   = lat_r;
                rd[PGM_VEN]   = ven_r;
            end
            default: begin
                rd = '0;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_wb_dat <= '0;
        end else if (req && !ack_r) begin
            o_wb_dat <= {24'h000000, rd};
        end
    end

endmodule

// ### logic/eepc_prot_decode.sv
// Purpose: maps an array offset onto its protect block
// Assumes: offset below the array size
// Notes:   purely combinational
`timescale 1ns/100ps
module eepc_prot_decode (
    // address and protect bits
    input  wire logic [9:0] i_addr,
    input  wire logic [4:0] i_bprot,
    // result
    output logic            o_hit
);
    import eepc_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // block index, blocks shrink toward the top of the array
    logic [2:0] blk;
    always_comb begin
        if (i_addr >= BLK0_START) begin
            blk = 3'h0;
        end else if (i_addr >= BLK1_START) begin
            blk = 3'h1;
        end else if (i_addr >= BLK2_START) begin
            blk = 3'h2;
        end else if (i_addr >= BLK3_START) begin
            blk = 3'h3;
        end else begin
            blk = 3'h4;
        end
    end

    assign o_hit = i_bprot[blk];

endmodule

// ### logic/eepc_pump_ctrl.sv
// Purpose: high voltage and charge pump gating
// Assumes: i_stop high for the whole stop mode
// Notes:   outputs lag their causes by one clock
`timescale 1ns/100ps
module eepc_pump_ctrl (
    // clock and reset
    input  wire logic               i_clk,
    input  wire logic               i_rstn,
    // controls
    input  wire logic               i_ven,
    input  wire logic               i_stop,
    input  wire logic               i_rc_sel,
    input  wire logic [7:0]         i_tst,
    // to the analog side
    output eepc_pkg::eepc_pump_t    o_pump
);
    import eepc_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // stop removes voltage but leaves the enable bit alone
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_pump <= '0;
        end else begin
            o_pump.hv_apply   <= i_ven && !i_stop;
            o_pump.pump_en    <= i_ven && !i_stop
                                 && !i_tst[TST_CPD];
            o_pump.rc_osc_en  <= i_rc_sel && !i_stop;
            o_pump.clk_sel_rc <= i_rc_sel;
            o_pump.ramp_en    <= !i_tst[TST_CPRD];
            o_pump.monitor    <= i_tst[TST_CPM];
            o_pump.margin     <= i_tst[TST_VOLTAGE_MARGIN_TEST];
        end
    end

endmodule

// ### verification/eepc_ctrl_props.sv
// Purpose: port-level assertions for the nvm program/erase control
// Assumes: one clock domain, synchronous active-low reset
// Notes:   bound onto every eepc_ctrl instance
`timescale 1ns/100ps
module eepc_ctrl_chk
    import eepc_pkg::*;
(
    // clock and reset
    input  wire logic               i_clk,
    input  wire logic               i_rstn,
    // bus and mode inputs
    input  wire logic               i_wb_cyc,
    input  wire logic               i_wb_stb,
    input  wire logic               i_wb_we,
    input  wire logic [WB_AW-1:0]   i_wb_adr,
    input  wire logic               i_wait,
    input  wire logic               i_stop,
    // design outputs
    input  wire logic [WB_DW-1:0]   o_wb_dat,
    input  wire logic               o_wb_ack,
    input  wire logic               o_arr_rd_block,
    input  wire eepc_op_cmd_t       o_op,
    input  wire eepc_pump_t         o_pump,
    input  wire logic               o_clk_en
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    ////////////////////////////////////////////////////////////////////////
    // bus answer comes exactly one cycle after the request is seen
    a_ack_next: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack
        |=> o_wb_ack) else $error("bus answer late");
    a_pgm_zero_bits: assert property (o_wb_ack && !i_wb_we
        && i_wb_adr[9:2] == IDX_PGM |-> o_wb_dat[31:5] == 27'h0000004
        || o_wb_dat[31:5] == 27'h0000000) else $error("pgm read bits");
    // clock gating only ever happens in wait mode
    a_wait_clk_gate: assert property (!i_wait |=> o_clk_en)
        else $error("clock gated outside wait");
    a_stop_hv_off: assert property (i_stop |=> !o_pump.hv_apply)
        else $error("voltage kept in stop");
    a_op_blocks_rd: assert property (o_op.active |-> o_arr_rd_block)
        else $error("array readable during operation");
    // latches may not move while the operation runs
    a_lat_frozen: assert property (o_op.active ##1 o_op.active
        |-> $stable(o_op.lat)) else $error("latch moved");
    a_erase_ones: assert property (o_op.active
        && o_op.kind != OP_PROGRAM |-> o_op.lat.data == 16'hFFFF)
        else $error("erase data not all ones");
    a_ven_after_lat: assert property ($rose(o_op.active)
        |-> $past(o_arr_rd_block)) else $error("voltage without latch");
    // main scenarios reached
    c_op: cover property (o_op.active);
    c_gate: cover property (!o_clk_en);
    c_wr: cover property (o_wb_ack && i_wb_we);
endmodule
bind eepc_ctrl eepc_ctrl_chk i_chk (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
    .i_wb_adr(i_wb_adr), .i_wait(i_wait), .i_stop(i_stop),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_op(o_op),
    .o_arr_rd_block(o_arr_rd_block), .o_pump(o_pump), .o_clk_en(o_clk_en));

// ### verification/test_eeprom_program_erase_control.sv
// Purpose: self-checking bench for the nvm program/erase control
// Assumes: one bus answer per request, registered outputs
// Notes:   software timing of program/erase is not modelled
`timescale 1ns/100ps
module test_eeprom_program_erase_control;
    import eepc_pkg::*;
    logic               clk, rstn, cyc, stb, we, awr, aword, smn, wt, stp;
    logic [WB_AW-1:0]   adr;
    logic [WB_DW-1:0]   wdat, rdat;
    logic [3:0]         sel;
    logic [9:0]         aadr;
    logic [15:0]        adat;
    logic               ack, rdblk, clken;
    eepc_op_cmd_t       dop;
    eepc_pump_t         pump;
    int                 fails, num_checks, cycles;
    logic [7:0]         q;
    eepc_ctrl i_dut (.i_clk(clk), .i_rstn(rstn), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat),
        .i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack), .i_arr_wr(awr),
        .i_arr_addr(aadr), .i_arr_word(aword), .i_arr_wdata(adat),
        .i_special_mode_n(smn), .i_wait(wt), .i_stop(stp),
        .o_arr_rd_block(rdblk), .o_op(dop), .o_pump(pump), .o_clk_en(clken));
    ////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            end_of_test();
        end
    end
    // verdict
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    // ends on an edge so later stimulus lands there; outputs read then
    // still show the state after edge n
    task automatic tick(input int n);
        repeat (n + 1) @(posedge clk);
    endtask
    // one classic cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] idx, d);
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w;
        adr <= {idx, 2'b00}; wdat <= {24'h0, d};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rdat[7:0];
        cyc <= 1'b0; stb <= 1'b0;
    endtask
    task automatic rdchk(input string s, input logic [7:0] idx, e);
        wb(1'b0, idx, 8'h00);
        chk(s, 32'(e), 32'(q));
    endtask
    // single-cycle cpu write into the array
    task automatic aw(input logic [9:0] a, input logic w, input logic [15:0] d);
        @(posedge clk);
        awr <= 1'b1; aadr <= a; aword <= w; adat <= d;
        @(posedge clk);
        awr <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rdchk("cfg", IDX_CFG, 8'h00);
        rdchk("prot", IDX_PROT, 8'h00);
        rdchk("pgm", IDX_PGM, 8'h80);
        rdchk("unmapped", 8'h10, 8'h00);
    endtask
    task automatic t_test();
        wb(1'b1, IDX_TST, 8'hFF);
        rdchk("tst normal", IDX_TST, 8'h00);
        smn <= 1'b0;
        wb(1'b1, IDX_TST, 8'hCF);
        rdchk("tst special", IDX_TST, 8'hCF);
        chk("monitor", 32'h1, 32'(pump.monitor));
        wb(1'b1, IDX_TST, 8'h00);
    endtask
    task automatic t_clock();
        wb(1'b1, IDX_CFG, 8'h81);
        wt <= 1'b1;
        tick(2);
        chk("clk_en wait", 32'h0, 32'(clken));
        chk("rc sel", 32'h1, 32'(pump.clk_sel_rc));
        wt <= 1'b0;
        wb(1'b1, IDX_CFG, 8'h00);
        tick(2);
        chk("clk_en run", 32'h1, 32'(clken));
        chk("rc off", 32'h0, 32'(pump.rc_osc_en));
    endtask
    task automatic t_prog();
        logic [7:0] m[4] = '{8'h02, 8'h16, 8'h0E, 8'h06};
        eepc_op_kind_t k[4] = '{OP_PROGRAM, OP_ERASE_LOC, OP_ERASE_ROW,
                                OP_ERASE_BULK};
        rdchk("pgm", IDX_PGM, 8'h80);
        wb(1'b1, IDX_PGM, 8'h03);
        rdchk("lat only", IDX_PGM, 8'h02);
        chk("rd block", 32'h1, 32'(rdblk));
        aw(10'h011, 1'b1, 16'hABCD);
        aw(10'h020, 1'b0, 16'h0055);
        tick(2);
        chk("lat", 32'({10'h011, 16'h00CD, 1'b0}), 32'(dop.lat));
        wb(1'b1, IDX_PGM, 8'h03);
        tick(2);
        chk("hv", 32'h1, 32'(pump.hv_apply));
        aw(10'h100, 1'b0, 16'h0011);
        wb(1'b1, IDX_PROT, 8'h10);
        rdchk("prot busy", IDX_PROT, 8'h00);
        chk("frozen", 32'({10'h011, 16'h00CD, 1'b0}), 32'(dop.lat));
        stp <= 1'b1;
        tick(2);
        chk("stop hv", 32'h0, 32'(pump.hv_apply));
        stp <= 1'b0;
        tick(2);
        chk("resume hv", 32'h1, 32'(pump.hv_apply));
        wb(1'b1, IDX_PGM, 8'h1F);
        rdchk("mode frozen", IDX_PGM, 8'h03);
        wb(1'b1, IDX_PGM, 8'h02);
        aw(10'h040, 1'b1, 16'h1234);
        tick(2);
        chk("rearm", 32'({10'h040, 16'h1234, 1'b1}), 32'(dop.lat));
        // programming and each erase size, mode and latch bits written before the voltage bit
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, IDX_PGM, m[i]);
            aw(10'h040, 1'b1, 16'h1234);
            wb(1'b1, IDX_PGM, m[i] | 8'h01);
            tick(2);
            chk("kind", 32'(k[i]), 32'(dop.kind));
            chk("active", 32'h1, 32'(dop.active));
            wb(1'b1, IDX_PGM, m[i]);
        end
        wb(1'b1, IDX_TST, 8'h80);
        tick(2);
        chk("odd rows", 32'(OP_BULK_ODD), 32'(dop.kind));
        wb(1'b1, IDX_TST, 8'h00);
        wb(1'b1, IDX_PGM, 8'h86);
        aw(10'h040, 1'b1, 16'h1234);
        wb(1'b1, IDX_PGM, 8'h87);
        tick(2);
        chk("bulk protect", 32'h0, 32'(dop.active));
        wb(1'b1, IDX_PGM, 8'h02);
        wb(1'b1, IDX_PROT, 8'h10);
        aw(10'h040, 1'b1, 16'h1234);
        wb(1'b1, IDX_PGM, 8'h03);
        tick(2);
        chk("block protect", 32'h0, 32'(dop.active));
        wb(1'b1, IDX_PGM, 8'h00);
        tick(2);
        chk("rd free", 32'h0, 32'(rdblk));
    endtask
    // fresh reset so the single normal-mode write is still unused
    task automatic t_lock();
        rstn <= 1'b0;
        smn <= 1'b1;
        tick(4);
        rstn <= 1'b1;
        wb(1'b1, IDX_CFG, 8'h02);
        wb(1'b1, IDX_PROT, 8'h1F);
        rdchk("prot locked", IDX_PROT, 8'h00);
        wb(1'b1, IDX_PGM, 8'h00);
        rdchk("bulk_erase_protect locked", IDX_PGM, 8'h80);
        wb(1'b1, IDX_CFG, 8'h00);
        rdchk("lock once", IDX_CFG, 8'h02);
        smn <= 1'b0;
        wb(1'b1, IDX_CFG, 8'h00);
        rdchk("lock special", IDX_CFG, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        rstn = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; sel = 4'hF;
        adr = '0; wdat = '0; awr = 1'b0; aadr = '0; aword = 1'b0;
        adat = '0; smn = 1'b1; wt = 1'b0; stp = 1'b0;
        fails = 0; num_checks = 0; cycles = 0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_test();
        t_clock();
        t_prog();
        t_lock();
        end_of_test();
    end
endmodule
